// >>> rtl/bcs_activity.sv
`timescale 1ns/1ns
`include "bcs_map.svh"

module bcs_activity (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pin from outside the clock domain
	input  wire logic pin,
	// Synchronised view
	output logic      level,
	output logic      rise,
	output logic      missing
);

	bcs_pkg::bcs_act_state_type r_r;
	bcs_pkg::bcs_act_state_type r_nxt;
	logic                       toggle;

	assign toggle  = r_r.s2 ^ r_r.s3;
	assign level   = r_r.s2;
	assign rise    = r_r.s2 & ~r_r.s3;
	assign missing = r_r.miss;

	always_comb begin
		r_nxt    = r_r;
		r_nxt.s1 = pin;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		if (toggle) begin // see [RULE1] [RULE2] [RULE3]
			r_nxt.cnt  = 8'h00;
			r_nxt.miss = 1'b0;
		end else if (r_r.cnt == 8'(`BCS_MISS_CYC - 1)) begin
			r_nxt.miss = 1'b1;
		end else begin
			r_nxt.cnt = r_r.cnt + 8'h01;
		end
	end

	// Nothing has been seen at reset, so the input counts as missing.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_r      <= '0;
			r_r.miss <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_quiet_sets_miss: assert property ( // see [RULE1] [RULE2] [RULE3]
		(!toggle && r_r.cnt == 8'(`BCS_MISS_CYC - 1)) |=> missing)
		else $error("quiet input did not raise missing");
	chk_edge_clears_miss: assert property ( // see [RULE1] [RULE2] [RULE3]
		toggle |=> !missing ##1 (r_r.cnt <= 8'h01))
		else $error("input activity did not clear missing");

endmodule : bcs_activity

// >>> rtl/bcs_ber_checker_status.sv
// Notes on behaviour
// [RULE1] Generator clock missing flag rises when no generator clock edges arrive.
// [RULE2] Detector clock missing flag rises when no detector clock edges arrive.
// [RULE3] Input signal missing flag rises when detector data stops toggling.
// [RULE4] Alignment lost flag rises when window errors exceed the programmed threshold.
// [RULE5] Error flag rises whenever a received bit differs from the reference.
// [RULE6] Input amplifier is disconnected when the input is out of range.
// [RULE7] Writing new input settings reconnects the input amplifier.
// [RULE8] A still out-of-range input disconnects the amplifier again at once.
// [RULE9] Automatic mode reseeds the reference repeatedly while alignment is lost.
// [RULE10] Threshold defaults to one error in a thousand bits, programmable.
// [RULE11] Invert setting compares against the complemented reference pattern.
// [RULE12] Reference pattern follows the generator's or is chosen independently.
// [RULE13] Generator injects periodic bit errors while insertion is enabled.
// [RULE14] A realign command restarts alignment of the reference on demand.
// [RULE15] Manual mode never realigns unless the realign command is given.
// [RULE16] Manual mode keeps reporting loss and counting errors through accumulation.
// [RULE17] Compared bits, errors, errored ones and errored zeros are accumulated.
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "bcs_map.svh"

module bcs_ber_checker_status (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	// Link pins
	input  wire logic                genClkPin,
	input  wire logic                detClkPin,
	input  wire logic                detDataPin,
	input  wire logic                inRangeBad,
	output logic                     genDataOut,
	// Input stage control
	output logic                     ampEnable,
	output bcs_pkg::bcs_incfg_type   inCfg,
	// Indicators
	output bcs_pkg::bcs_flags_type   flags,
	output logic                     irq
);

	bcs_pkg::bcs_state_type r_r;
	bcs_pkg::bcs_state_type r_nxt;

	logic                   genLevel;
	logic                   genRise;
	logic                   genMiss;
	logic                   detRise;
	logic                   detMiss;
	logic                   dataLevel;
	logic                   dataMiss;
	logic                   genPred;
	logic                   refPred;
	logic                   refSel;
	logic                   addrPhase;
	logic                   wrCfg;
	logic                   cmpNow;
	logic                   rxBit;
	logic                   mism;
	logic [15:0]            errSum;
	logic                   lossHit;
	logic                   winEnd;
	logic                   rngBad;
	logic [31:0]            liveWord;
	bcs_pkg::bcs_flags_type live;

	bcs_activity u_genAct (
		.clk     (clk),
		.rst     (rst),
		.pin     (genClkPin),
		.level   (genLevel),
		.rise    (genRise),
		.missing (genMiss)
	);

	bcs_activity u_detAct (
		.clk     (clk),
		.rst     (rst),
		.pin     (detClkPin),
		.level   (),
		.rise    (detRise),
		.missing (detMiss)
	);

	bcs_activity u_dataAct (
		.clk     (clk),
		.rst     (rst),
		.pin     (detDataPin),
		.level   (dataLevel),
		.rise    (),
		.missing (dataMiss)
	);

	bcs_prbs u_genPrbs (
		.clk   (clk),
		.rst   (rst),
		.step  (genRise),
		.useIn (1'b0),
		.inBit (1'b0),
		.sel   (r_r.ctrl.genPatSel),
		.pred  (genPred)
	);

	bcs_prbs u_refPrbs (
		.clk   (clk),
		.rst   (rst),
		.step  (detRise),
		.useIn (r_r.sync == bcs_pkg::SYNC_ACQ),
		.inBit (rxBit),
		.sel   (refSel),
		.pred  (refPred)
	);

	assign refSel    = r_r.ctrl.trackGen ? r_r.ctrl.genPatSel : r_r.ctrl.detPatSel; // see [RULE12]
	assign addrPhase = hsel && htrans[1] && hready;
	assign wrCfg     = r_r.dpWrite && (r_r.dpAddr == `BCS_OFS_INCFG);
	assign rngBad    = r_r.rng2;

	// Data is sampled by the same synchroniser depth as the clock it is judged against.
	assign rxBit   = dataLevel ^ r_r.ctrl.invert; // see [RULE11]
	assign cmpNow  = detRise && (r_r.sync != bcs_pkg::SYNC_ACQ);
	assign mism    = cmpNow && (rxBit != refPred); // see [RULE5]
	assign errSum  = r_r.winErrs + {15'h0000, mism};
	assign lossHit = cmpNow && (errSum > r_r.errLimit); // see [RULE4]
	assign winEnd  = cmpNow && ((r_r.winBits + 16'h0001) >= r_r.window);

	always_comb begin
		live            = '0;
		live.genClkMiss = genMiss;
		live.detClkMiss = detMiss;
		live.dataMiss   = dataMiss;
		live.syncLoss   = (r_r.sync != bcs_pkg::SYNC_LOCK);
		live.errSeen    = r_r.errSeen;
		live.ampOff     = !r_r.ampOn;
	end

	assign liveWord  = {22'h000000, r_r.sync, r_r.accActive, r_r.ampOn, live};
	assign flags     = live;
	assign irq       = |(r_r.status & r_r.mask);
	assign hrdata    = r_r.rdata;
	assign hreadyout = !r_r.rdWait;
	assign hresp     = 1'b0;
	assign ampEnable = r_r.ampOn;
	assign inCfg     = r_r.inCfg;
	assign genDataOut = r_r.genData;

	always_comb begin
		r_nxt               = r_r;
		r_nxt.ctrl.realign  = 1'b0;
		r_nxt.ctrl.accStart = 1'b0;

		// Bus: writes land one cycle after the address; reads take one wait state.
		r_nxt.dpWrite = addrPhase && hwrite;
		r_nxt.rdWait  = addrPhase && !hwrite;
		if (addrPhase) begin
			r_nxt.dpAddr = haddr[7:0];
		end
		if (r_r.rdWait) begin
			case (r_r.dpAddr)
				`BCS_OFS_CTRL:    r_nxt.rdata = {24'h000000, r_r.ctrl[7:0] & 8'h3F};
				`BCS_OFS_THRESH:  r_nxt.rdata = {r_r.window, r_r.errLimit};
				`BCS_OFS_INCFG:   r_nxt.rdata = {8'h00, r_r.inCfg};
				`BCS_OFS_LIVE:    r_nxt.rdata = liveWord;
				`BCS_OFS_STATUS:  r_nxt.rdata = {26'h0000000, r_r.status};
				`BCS_OFS_MASK:    r_nxt.rdata = {26'h0000000, r_r.mask};
				`BCS_OFS_BITCNT:  r_nxt.rdata = r_r.bitCnt;
				`BCS_OFS_ERRCNT:  r_nxt.rdata = r_r.errCnt;
				`BCS_OFS_ERR1CNT: r_nxt.rdata = r_r.err1Cnt;
				`BCS_OFS_ERR0CNT: r_nxt.rdata = r_r.err0Cnt;
				`BCS_OFS_ACCLEN:  r_nxt.rdata = r_r.accLen;
				default:          r_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// Status bits follow the live flags; a set in the clearing cycle wins.
		r_nxt.status = r_r.status | live;
		if (r_r.dpWrite) begin
			case (r_r.dpAddr)
				`BCS_OFS_CTRL: begin
					r_nxt.ctrl     = bcs_pkg::bcs_ctrl_type'(hwdata);
					r_nxt.ctrl.rsv = 24'h000000;
				end
				`BCS_OFS_THRESH: begin
					r_nxt.errLimit = hwdata[`BCS_THR_LIMIT]; // see [RULE10]
					r_nxt.window   = hwdata[`BCS_THR_WINDOW];
				end
				`BCS_OFS_INCFG:  r_nxt.inCfg = bcs_pkg::bcs_incfg_type'(hwdata[23:0]);
				`BCS_OFS_STATUS: r_nxt.status = (r_r.status & ~hwdata[5:0]) | live;
				`BCS_OFS_MASK:   r_nxt.mask = bcs_pkg::bcs_flags_type'(hwdata[5:0]);
				`BCS_OFS_ACCLEN: r_nxt.accLen = hwdata;
				default: begin
				end
			endcase
		end

		// Input amplifier protection. The range comparator is only trusted once resynchronised.
		r_nxt.rng1 = inRangeBad;
		r_nxt.rng2 = r_r.rng1;
		if (wrCfg) begin
			r_nxt.ampOn = 1'b1; // see [RULE7]
		end else if (rngBad) begin
			r_nxt.ampOn = 1'b0; // see [RULE6] [RULE8]
		end

		// Generator with periodic error insertion.
		if (genRise) begin
			r_nxt.insCnt  = r_r.insCnt + 8'h01;
			r_nxt.genData = genPred ^ (r_r.ctrl.errInsert && r_r.insCnt == `BCS_INS_GAP); // see [RULE13]
		end

		// Consecutive fixed error windows, restarted at each window end, for alignment judgement.
		if (cmpNow) begin
			r_nxt.errSeen = mism;
			if (winEnd) begin
				r_nxt.winBits = 16'h0000;
				r_nxt.winErrs = 16'h0000;
			end else begin
				r_nxt.winBits = r_r.winBits + 16'h0001;
				r_nxt.winErrs = errSum;
			end
		end

		unique case (r_r.sync)
			bcs_pkg::SYNC_ACQ: begin
				if (detRise) begin
					r_nxt.acqCnt = r_r.acqCnt + 4'h1;
					if (r_r.acqCnt == `BCS_ACQ_BITS) begin
						r_nxt.sync    = bcs_pkg::SYNC_LOCK;
						r_nxt.winBits = 16'h0000;
						r_nxt.winErrs = 16'h0000;
					end
				end
			end
			bcs_pkg::SYNC_LOCK: begin
				if (lossHit) begin
					r_nxt.sync = bcs_pkg::SYNC_LOST; // see [RULE4]
				end
			end
			bcs_pkg::SYNC_LOST: begin
				// Manual mode stays here and keeps counting. // see [RULE15] [RULE16]
				if (r_r.ctrl.autoSync) begin
					r_nxt.sync   = bcs_pkg::SYNC_ACQ; // see [RULE9]
					r_nxt.acqCnt = 4'h0;
				end
			end
		endcase
		if (r_r.ctrl.realign) begin
			r_nxt.sync   = bcs_pkg::SYNC_ACQ; // see [RULE14]
			r_nxt.acqCnt = 4'h0;
		end

		// Accumulation stops by itself after the programmed number of compared bits.
		if (r_r.ctrl.accStart) begin
			r_nxt.bitCnt    = 32'h0000_0000;
			r_nxt.errCnt    = 32'h0000_0000;
			r_nxt.err1Cnt   = 32'h0000_0000;
			r_nxt.err0Cnt   = 32'h0000_0000;
			r_nxt.accActive = 1'b1;
		end else if (r_r.accActive && cmpNow) begin
			r_nxt.bitCnt  = r_r.bitCnt + 32'h0000_0001; // see [RULE17]
			r_nxt.errCnt  = r_r.errCnt + {31'h00000000, mism};
			r_nxt.err1Cnt = r_r.err1Cnt + {31'h00000000, mism & refPred};
			r_nxt.err0Cnt = r_r.err0Cnt + {31'h00000000, mism & ~refPred};
			if ((r_r.bitCnt + 32'h0000_0001) >= r_r.accLen) begin
				r_nxt.accActive = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_r          <= '0;
			r_r.ctrl     <= `BCS_CTRL_RST;
			r_r.errLimit <= `BCS_LIMIT_RST; // see [RULE10]
			r_r.window   <= `BCS_WINDOW_RST;
			r_r.accLen   <= `BCS_ACCLEN_RST;
			r_r.ampOn    <= 1'b1;
			r_r.sync     <= bcs_pkg::SYNC_ACQ;
		end else begin
			r_r <= r_nxt;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_amp_range_off: assert property ( // see [RULE6] [RULE8]
		(r_r.ampOn && rngBad && !wrCfg) |=> (!ampEnable && flags.ampOff))
		else $error("amplifier stayed on with input out of range");
	chk_amp_reconnect: assert property ( // see [RULE7]
		wrCfg |=> ampEnable)
		else $error("settings write did not reconnect amplifier");
	chk_loss_raise: assert property ( // see [RULE4]
		(r_r.sync == bcs_pkg::SYNC_LOCK && lossHit && !r_r.ctrl.realign)
		|=> (r_r.sync == bcs_pkg::SYNC_LOST && flags.syncLoss))
		else $error("threshold exceeded without loss of alignment");
	chk_error_flag: assert property ( // see [RULE5]
		mism |=> flags.errSeen ##1 r_r.status.errSeen)
		else $error("bit mismatch did not raise error flag");
	chk_auto_reseed: assert property ( // see [RULE9]
		(r_r.sync == bcs_pkg::SYNC_LOST && r_r.ctrl.autoSync)
		|=> (r_r.sync == bcs_pkg::SYNC_ACQ && r_r.acqCnt == 4'h0))
		else $error("automatic mode did not reseed reference");
	chk_manual_hold: assert property ( // see [RULE15] [RULE16]
		(r_r.sync == bcs_pkg::SYNC_LOST && !r_r.ctrl.autoSync && !r_r.ctrl.realign)
		|=> (r_r.sync == bcs_pkg::SYNC_LOST && flags.syncLoss))
		else $error("manual mode left loss state on its own");
	chk_realign_cmd: assert property ( // see [RULE14]
		r_r.ctrl.realign |=> (r_r.sync == bcs_pkg::SYNC_ACQ))
		else $error("realign command ignored");
	chk_acc_count: assert property ( // see [RULE17]
		(r_r.accActive && cmpNow && !r_r.ctrl.accStart)
		|=> (r_r.bitCnt == $past(r_r.bitCnt) + 32'h0000_0001))
		else $error("compared bit not accumulated");

	cov_lock_then_loss: cover property (
		r_r.sync == bcs_pkg::SYNC_LOCK ##1 r_r.sync == bcs_pkg::SYNC_LOST);
	cov_reconnect_fail: cover property (wrCfg ##1 ampEnable ##1 !ampEnable);
	cov_inserted_error: cover property (r_r.ctrl.errInsert && mism);

endmodule : bcs_ber_checker_status

// >>> rtl/bcs_map.svh
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH

// Register byte offsets, low address byte only.
`define BCS_OFS_CTRL    8'h00
`define BCS_OFS_THRESH  8'h04
`define BCS_OFS_INCFG   8'h08
`define BCS_OFS_LIVE    8'h0C
`define BCS_OFS_STATUS  8'h10
`define BCS_OFS_MASK    8'h14
`define BCS_OFS_BITCNT  8'h18
`define BCS_OFS_ERRCNT  8'h1C
`define BCS_OFS_ERR1CNT 8'h20
`define BCS_OFS_ERR0CNT 8'h24
`define BCS_OFS_ACCLEN  8'h28

// Reset values.
`define BCS_CTRL_RST    32'h0000_0005
`define BCS_LIMIT_RST   16'h0001
`define BCS_WINDOW_RST  16'h03E8
`define BCS_ACCLEN_RST  32'h000F_4240
`define BCS_PRBS_RST    15'h7FFF

// Field positions inside THRESH.
`define BCS_THR_LIMIT   15:0
`define BCS_THR_WINDOW  31:16

// Timing.
`define BCS_CLK_NS      50
`define BCS_MISS_NS     8000
`define BCS_MISS_CYC    ((`BCS_MISS_NS + `BCS_CLK_NS - 1) / `BCS_CLK_NS)
`define BCS_ACQ_BITS    4'hE
`define BCS_INS_GAP     8'hFF

`endif

// >>> rtl/bcs_pkg.sv
package bcs_pkg;

	typedef enum logic [1:0] {SYNC_ACQ, SYNC_LOCK, SYNC_LOST} bcs_sync_type;

	typedef struct packed {
		logic [23:0] rsv;
		logic        accStart;
		logic        realign;
		logic        errInsert;
		logic        detPatSel;
		logic        genPatSel;
		logic        trackGen;
		logic        invert;
		logic        autoSync;
	} bcs_ctrl_type;

	typedef struct packed {
		logic ampOff;
		logic errSeen;
		logic syncLoss;
		logic dataMiss;
		logic detClkMiss;
		logic genClkMiss;
	} bcs_flags_type;

	typedef struct packed {
		logic [7:0] term;
		logic [7:0] decThr;
		logic [7:0] range;
	} bcs_incfg_type;

	typedef struct packed {
		logic       s1;
		logic       s2;
		logic       s3;
		logic [7:0] cnt;
		logic       miss;
	} bcs_act_state_type;

	typedef struct packed {
		logic [14:0] sr;
	} bcs_prbs_state_type;

	typedef struct packed {
		bcs_ctrl_type  ctrl;
		logic [15:0]   errLimit;
		logic [15:0]   window;
		bcs_incfg_type inCfg;
		bcs_flags_type status;
		bcs_flags_type mask;
		logic [31:0]   bitCnt;
		logic [31:0]   errCnt;
		logic [31:0]   err1Cnt;
		logic [31:0]   err0Cnt;
		logic [31:0]   accLen;
		logic          accActive;
		bcs_sync_type  sync;
		logic [3:0]    acqCnt;
		logic [15:0]   winBits;
		logic [15:0]   winErrs;
		logic          ampOn;
		logic          errSeen;
		logic          genData;
		logic [7:0]    insCnt;
		logic          rng1;
		logic          rng2;
		logic          dpWrite;
		logic          rdWait;
		logic [7:0]    dpAddr;
		logic [31:0]   rdata;
	} bcs_state_type;

endpackage : bcs_pkg

// >>> rtl/bcs_prbs.sv
`timescale 1ns/1ns
`include "bcs_map.svh"

module bcs_prbs (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control
	input  wire logic step,
	input  wire logic useIn,
	input  wire logic inBit,
	input  wire logic sel,
	// Next bit the pattern predicts
	output logic      pred
);

	bcs_pkg::bcs_prbs_state_type r_r;
	bcs_pkg::bcs_prbs_state_type r_nxt;

	// Long pattern taps 15 and 14, short pattern taps 7 and 6.
	function automatic logic feedback(input logic [14:0] s, input logic longSel);
		feedback = longSel ? (s[14] ^ s[13]) : (s[6] ^ s[5]);
	endfunction : feedback

	assign pred = feedback(r_r.sr, sel);

	// Seeding from the received stream moves the reference to where the data is.
	always_comb begin
		r_nxt = r_r;
		if (step) begin
			r_nxt.sr = {r_r.sr[13:0], useIn ? inBit : feedback(r_r.sr, sel)};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_r.sr <= `BCS_PRBS_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

endmodule : bcs_prbs

// >>> verif/bcs_link_partner.sv
`timescale 1ns/1ns

module bcs_link_partner (
	// Commands from the bench
	input  wire logic run,
	input  wire logic dataOn,
	input  wire logic invData,
	input  wire logic flipReq,
	// Loopback from the generator
	input  wire logic genData,
	// Link lines towards the detector
	output logic      linkClk,
	output logic      detData
);
	logic capBit;
	logic flipSeen;

	initial begin
		linkClk = 1'b0;
		detData = 1'b0;
		capBit = 1'b0;
		flipSeen = 1'b0;
		#37;
		forever begin
			#200;
			if (run || linkClk)
				linkClk = ~linkClk;
		end
	end

	// The generator settles about three clk after the rise, so take its bit a period later.
	always @(posedge linkClk)
		capBit = genData;

	always @(negedge linkClk) begin
		detData = dataOn & (capBit ^ invData ^ (flipReq != flipSeen));
		flipSeen = flipReq;
	end

	// A stopped link leaves no stale level behind: the undriven line wanders.
	always #50
		if (!run && !linkClk)
			detData = ~detData;
endmodule : bcs_link_partner

// >>> verif/tb.sv
`timescale 1ns/1ns
`include "bcs_map.svh"

module tb;
	logic                   clk;
	logic                   rst;
	logic                   hsel;
	logic [31:0]            haddr;
	logic [1:0]             htrans;
	logic                   hwrite;
	logic [2:0]             hsize;
	logic [31:0]            hwdata;
	logic [31:0]            hrdata;
	logic                   hreadyout;
	logic                   hresp;
	logic                   inRangeBad;
	logic                   genDataOut;
	logic                   ampEnable;
	bcs_pkg::bcs_incfg_type inCfg;
	bcs_pkg::bcs_flags_type flags;
	logic                   irq;
	logic                   linkClk;
	logic                   detData;
	logic                   run;
	logic                   dataOn;
	logic                   invData;
	logic                   flipReq;
	logic [31:0]            rng;
	logic [31:0]            v;
	logic [31:0]            w;
	logic [31:0]            expQ[$];
	logic                   prevRdy;
	int                     ampRises;
	int                     n_errors;
	int                     samples_checked;
	int                     cyc;

	bcs_ber_checker_status i_bcs_ber_checker_status (
		.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.genClkPin(linkClk), .detClkPin(linkClk), .detDataPin(detData),
		.inRangeBad(inRangeBad), .genDataOut(genDataOut), .ampEnable(ampEnable),
		.inCfg(inCfg), .flags(flags), .irq(irq)
	);

	bcs_link_partner i_bcs_link_partner (
		.run(run), .dataOn(dataOn), .invData(invData), .flipReq(flipReq),
		.genData(genDataOut), .linkClk(linkClk), .detData(detData)
	);

	always #25 clk = ~clk;

	always @(posedge ampEnable)
		ampRises++;

	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xs

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rdv(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask : rdv

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		expQ.push_back(e);
		bus(1'b0, a, 32'h0, r);
	endtask : rdc

	task automatic bits(input int n);
		repeat (n * 8) @(posedge clk);
	endtask : bits

	// Registered outputs may trail a write by an edge, so look two edges on.
	task automatic settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic flipTwice();
		flipReq <= ~flipReq;
		bits(2);
		flipReq <= ~flipReq;
		bits(4);
	endtask : flipTwice

	// A read completes where hreadyout comes back after its one low cycle.
	always @(posedge clk) begin
		if (prevRdy === 1'b0 && hreadyout === 1'b1 && expQ.size() > 0) begin
			check(hrdata, expQ.pop_front());
			check({31'h0, hresp}, 32'h0);
		end
		prevRdy = hreadyout;
	end

	// The sequence needs about 8000 cycles; the ceiling leaves ample margin.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			report_and_stop();
		end
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		inRangeBad = 1'b0;
		run = 1'b0;
		dataOn = 1'b1;
		invData = 1'b0;
		flipReq = 1'b0;
		rng = 32'hED1543BD;
		prevRdy = 1'b1;
		ampRises = 0;
		n_errors = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rdc(`BCS_OFS_CTRL, `BCS_CTRL_RST);
		rdc(`BCS_OFS_THRESH, {`BCS_WINDOW_RST, `BCS_LIMIT_RST});
		rdc(`BCS_OFS_MASK, 32'h0);
		rdc(`BCS_OFS_ACCLEN, `BCS_ACCLEN_RST);
		rdc(8'h2C, 32'h0);
		repeat (200) @(posedge clk);
		settle();
		check({26'h0, flags}, 32'h0000000B);
		$display("test reset finished");
		run <= 1'b1;
		bits(40);
		settle();
		check({26'h0, flags}, 32'h0);
		wr(`BCS_OFS_CTRL, 32'h85);
		wr(`BCS_OFS_STATUS, 32'h3F);
		rdc(`BCS_OFS_STATUS, 32'h0);
		flipReq <= ~flipReq;
		bits(4);
		rdc(`BCS_OFS_STATUS, 32'h10);
		rdc(`BCS_OFS_ERRCNT, 32'h1);
		rdv(`BCS_OFS_ERR1CNT, v);
		rdv(`BCS_OFS_ERR0CNT, w);
		check(v + w, 32'h1);
		wr(`BCS_OFS_MASK, 32'h0);
		settle();
		check({31'h0, irq}, 32'h0);
		wr(`BCS_OFS_MASK, 32'h10);
		settle();
		check({31'h0, irq}, 32'h1);
		wr(`BCS_OFS_STATUS, 32'h10);
		settle();
		check({31'h0, irq}, 32'h0);
		$display("test error flag finished");
		wr(`BCS_OFS_STATUS, 32'h3F);
		flipTwice();
		rdv(`BCS_OFS_STATUS, v);
		check({31'h0, v[3]}, 32'h1);
		bits(40);
		settle();
		check({31'h0, flags.syncLoss}, 32'h0);
		wr(`BCS_OFS_CTRL, 32'h04);
		flipTwice();
		bits(40);
		settle();
		check({31'h0, flags.syncLoss}, 32'h1);
		wr(`BCS_OFS_CTRL, 32'h44);
		bits(40);
		settle();
		check({31'h0, flags.syncLoss}, 32'h0);
		$display("test sync finished");
		wr(`BCS_OFS_CTRL, 32'h07);
		invData <= 1'b1;
		bits(60);
		wr(`BCS_OFS_STATUS, 32'h3F);
		bits(20);
		rdc(`BCS_OFS_STATUS, 32'h0);
		invData <= 1'b0;
		wr(`BCS_OFS_CTRL, 32'h09);
		bits(80);
		wr(`BCS_OFS_STATUS, 32'h3F);
		bits(20);
		rdv(`BCS_OFS_STATUS, v);
		check({31'h0, v[3]}, 32'h1);
		wr(`BCS_OFS_CTRL, 32'h19);
		bits(80);
		wr(`BCS_OFS_STATUS, 32'h3F);
		bits(20);
		rdc(`BCS_OFS_STATUS, 32'h0);
		wr(`BCS_OFS_CTRL, 32'h25);
		bits(40);
		wr(`BCS_OFS_STATUS, 32'h3F);
		bits(300);
		rdv(`BCS_OFS_STATUS, v);
		check({31'h0, v[4]}, 32'h1);
		wr(`BCS_OFS_CTRL, 32'h05);
		bits(60);
		$display("test pattern settings finished");
		inRangeBad <= 1'b1;
		bits(1);
		settle();
		check({31'h0, ampEnable}, 32'h0);
		check({31'h0, flags.ampOff}, 32'h1);
		v = ampRises;
		w = xs() & 32'h00FFFFFF;
		wr(`BCS_OFS_INCFG, w);
		bits(1);
		settle();
		check(ampRises - v, 32'h1);
		check({31'h0, ampEnable}, 32'h0);
		check({8'h0, inCfg}, w);
		rdc(`BCS_OFS_INCFG, w);
		inRangeBad <= 1'b0;
		wr(`BCS_OFS_INCFG, xs() & 32'h00FFFFFF);
		bits(1);
		settle();
		check({31'h0, ampEnable}, 32'h1);
		$display("test amplifier finished");
		dataOn <= 1'b0;
		repeat (200) @(posedge clk);
		settle();
		check({30'h0, flags.dataMiss, flags.detClkMiss}, 32'h2);
		run <= 1'b0;
		repeat (200) @(posedge clk);
		settle();
		check({30'h0, flags.detClkMiss, flags.genClkMiss}, 32'h3);
		run <= 1'b1;
		dataOn <= 1'b1;
		bits(40);
		rdv(`BCS_OFS_STATUS, v);
		check(v & 32'h7, 32'h7);
		wr(`BCS_OFS_STATUS, 32'h3F);
		rdc(`BCS_OFS_STATUS, 32'h0);
		$display("test link loss finished");
		report_and_stop();
	end
endmodule : tb
